// ==== rtl/crc_guard_defines.vh ====
/*
 Constants for the serial register write guard: APB offsets, serial
 register indices, field positions, reset values and checksum settings.
 Assumes it is included by bare name from the design file.
*/
// Functional notes
// [RULE_01] Write frames are 16 bits, or 24 bits while write checking is on.
// [RULE_02] Host sets command bit 15 to mark a register write.
// [RULE_03] Bits 14 to 12 carry the register index, decoded by the device.
// [RULE_04] Bits 11 to 0 carry the value loaded into the selected register.
// [RULE_05] Read and write checking each have their own bit in the primary config.
// [RULE_06] With read checking on, an 8-bit checksum follows conversion and register data.
// [RULE_07] Read checksum covers both converter results and leaves on the first output.
// [RULE_08] Read checksum works in two-output, single-output and boost modes.
// [RULE_09] Setting the write-check bit needs a frame with a valid checksum.
// [RULE_10] With write checking on, writes lacking a correct checksum are discarded.
// [RULE_11] Clearing write checking also needs a valid checksum frame.
// [RULE_12] Checksum polynomial is x^8 + x^2 + x + 1.
// [RULE_13] Conversion message is result A followed by result B.
// [RULE_14] The top eight message bits are inverted before division.
// [RULE_15] The message is extended by eight zero bits before division.
// [RULE_16] The 8-bit remainder of modulo-2 division is the checksum.
// [RULE_17] Host clears bit 15 to request a read; data comes next frame.
// [RULE_18] Chip select low frames each transfer and starts a conversion.
// [RULE_19] Writes to read-only or unlisted indices change nothing.
// [RULE_20] Write checksum covers the 16-bit command and follows it in eight clocks.
// [RULE_21] Appended checksum bits go out MSB first right after the data.
`ifndef CRC_GUARD_DEFINES_VH
`define CRC_GUARD_DEFINES_VH

// APB byte offsets
`define APB_STATUS 4'h0
`define APB_CONFIG_VIEW 4'h4
`define APB_ALERT_FLAGS 4'h8

// Serial register indices
`define IDX_PRIMARY 3'h1
`define IDX_SECONDARY 3'h2
`define IDX_ALERT 3'h3
`define IDX_ALERT_LOW 3'h4
`define IDX_ALERT_HIGH 3'h5

// Reset values
`define PRIMARY_RESET 12'h000
`define SECONDARY_RESET 12'h000
`define ALERT_LOW_RESET 12'h000
`define ALERT_HIGH_RESET 12'hFFF

// Primary config fields
`define BIT_WRITE_CHECK 5
`define BIT_READ_CHECK 4
`define BIT_RES_BOOST 2
`define OSR_HI 8
`define OSR_LO 6
// Secondary config: single-output select
`define BIT_ONE_WIRE 8
`define SECONDARY_WMASK 12'h1FF
`define ALERT_SW_MASK 9'h133

// Command layout
`define CMD_WR_BIT 15
`define CMD_IDX_HI 14
`define CMD_IDX_LO 12
`define CMD_BITS 6'd16
`define CHECKED_BITS 6'd24
`define CRC_BITS 6'd8
`define BOOST_BITS 6'd2
`define CRC_POLY 8'h07
`define CNT_MAX 6'h3F
`define OUT_W 44

`endif

// ==== rtl/spi_register_write_crc_guard.v ====
/*
 Serial register port with checksum guard: decodes write and read
 commands sampled from the serial pins, discards unchecked writes while
 write checking is on, and shifts out conversion or register data with
 an optional appended checksum. Software sees status over APB.
 Assumes serial pins are asynchronous to pclk and the serial clock is
 well below a quarter of pclk; conversion results arrive on pclk.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "crc_guard_defines.vh"

module spi_register_write_crc_guard #(
   parameter RES_BITS = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire cs_n,
   input wire sclk,
   input wire sdi,
   output reg first_serial_out,
   output reg first_serial_oe,
   output reg second_serial_out,
   output reg second_serial_oe,
   input wire [17:0] conv_a_data,
   input wire [17:0] conv_b_data,
   output reg conv_start,
   output reg [11:0] primary_config,
   output reg [11:0] secondary_config
);

   // Serial checksum: top eight bits inverted, eight zeros appended
   function [7:0] crc8;
      input [35:0] msg;
      input [5:0] len;
      integer i;
      reg [7:0] c;
      reg b;
      begin
         c = 8'h00;
         for (i = 35; i >= 0; i = i - 1) begin
            if (i < len) begin
               b = msg[i];
               if (i >= len - `CRC_BITS) begin
                  b = ~b; // RULE_14
               end
               b = b ^ c[7];
               c = {c[6:0], 1'b0} ^ (b ? `CRC_POLY : 8'h00); // RULE_12 RULE_15 RULE_16
            end
         end
         crc8 = c;
      end
   endfunction

   reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
   reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
   reg sdi_s1_reg, sdi_s2_reg;
   reg [23:0] in_reg;
   reg [5:0] cnt_reg;
   reg [`OUT_W-1:0] out1_reg;
   reg [17:0] out2_reg;
   reg read_pending_reg;
   reg [2:0] read_idx_reg;
   reg [11:0] alert_low_reg, alert_high_reg;
   reg [8:0] alert_sw_reg;
   reg reject_reg;
   reg [7:0] reject_cnt_reg;

   wire cs_fall = cs_s3_reg & ~cs_s2_reg;
   wire cs_rise = ~cs_s3_reg & cs_s2_reg;
   wire sclk_rise = ~sclk_s3_reg & sclk_s2_reg;
   wire sclk_fall = sclk_s3_reg & ~sclk_s2_reg;
   wire active = ~cs_s2_reg;
   wire write_check = primary_config[`BIT_WRITE_CHECK];
   wire read_check = primary_config[`BIT_READ_CHECK];
   wire one_wire = secondary_config[`BIT_ONE_WIRE];
   wire boost = primary_config[`BIT_RES_BOOST] &
                (primary_config[`OSR_HI:`OSR_LO] != 3'h0);

   // Command fields of the captured frame
   wire [15:0] cmd = in_reg[23:8];
   wire [7:0] crc_rx = in_reg[7:0];
   wire cmd_write = cmd[`CMD_WR_BIT];
   wire [2:0] target_register_index = cmd[`CMD_IDX_HI:`CMD_IDX_LO]; // RULE_03
   wire [11:0] cmd_data = cmd[11:0]; // RULE_04
   wire framed = cnt_reg >= `CMD_BITS;
   wire checked = (cnt_reg >= `CHECKED_BITS) &&
                  (crc8({20'h00000, cmd}, `CMD_BITS) == crc_rx); // RULE_20
   wire sets_wcheck = cmd_write && (target_register_index == `IDX_PRIMARY) &&
                      cmd_data[`BIT_WRITE_CHECK];
   // Unchecked frames may write only while checking is off and must not set it
   wire write_ok = write_check ? checked : // RULE_10 RULE_11
                   (checked || (framed && !sets_wcheck)); // RULE_01 RULE_09
   wire do_write = cs_rise && framed && cmd_write && write_ok; // RULE_02
   wire do_reject = cs_rise && framed && cmd_write && !write_ok;
   wire do_read = cs_rise && framed && !cmd_write; // RULE_17

   // Serial register contents selected by a pending read index
   reg [11:0] reg_value;
   reg reg_valid;
   always @* begin
      reg_valid = 1'b1;
      case (read_idx_reg)
         `IDX_PRIMARY: reg_value = primary_config;
         `IDX_SECONDARY: reg_value = secondary_config;
         `IDX_ALERT: reg_value = {2'b00, reject_reg, alert_sw_reg & `ALERT_SW_MASK};
         `IDX_ALERT_LOW: reg_value = alert_low_reg;
         `IDX_ALERT_HIGH: reg_value = alert_high_reg;
         default: begin
            reg_value = 12'h000;
            reg_valid = 1'b0;
         end
      endcase
   end

   // Frame data for both outputs, left aligned, checksum after data
   reg [63:0] t1;
   reg [63:0] t2;
   reg [5:0] dw;
   reg [17:0] a_m, b_m;
   reg [7:0] crc_tx;
   reg [15:0] rd_word;
   always @* begin
      dw = RES_BITS[5:0] + (boost ? `BOOST_BITS : 6'd0); // RULE_08
      a_m = conv_a_data & ~(18'h3FFFF << dw);
      b_m = conv_b_data & ~(18'h3FFFF << dw);
      rd_word = {1'b0, read_idx_reg, reg_value};
      t1 = 64'h0;
      t2 = 64'h0;
      crc_tx = 8'h00;
      if (read_pending_reg && reg_valid) begin
         if (read_check) begin
            crc_tx = crc8({20'h00000, rd_word}, `CMD_BITS); // RULE_06
         end
         t1 = {rd_word, crc_tx, 40'h0};
      end else begin
         if (read_check) begin
            crc_tx = crc8({a_m, 18'h00000} >> (6'd18 - dw) | {18'h00000, b_m},
                          dw << 1); // RULE_07 RULE_13
         end
         if (one_wire) begin
            t1 = ({46'h0, a_m} << (7'd64 - dw)) |
                 ({46'h0, b_m} << (7'd64 - (dw << 1))) |
                 ({56'h0, crc_tx} << (7'd56 - (dw << 1))); // RULE_21
         end else begin
            t1 = ({46'h0, a_m} << (7'd64 - dw)) |
                 ({56'h0, crc_tx} << (7'd56 - dw)); // RULE_21
            t2 = {46'h0, b_m} << (7'd64 - dw);
         end
      end
   end

   // Pin synchronisers and edge history
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
         sclk_s1_reg <= 1'b1; // Idle high, no false edge after reset
         sclk_s2_reg <= 1'b1;
         sclk_s3_reg <= 1'b1;
         sdi_s1_reg <= 1'b0;
         sdi_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         sclk_s1_reg <= sclk;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
         sdi_s1_reg <= sdi;
         sdi_s2_reg <= sdi_s1_reg;
      end
   end

   // Input capture on falling serial clock, bit counting within the frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_reg <= 24'h000000;
         cnt_reg <= 6'd0;
      end else if (cs_fall) begin
         in_reg <= 24'h000000;
         cnt_reg <= 6'd0; // RULE_18
      end else if (active && sclk_fall) begin
         if (cnt_reg < `CHECKED_BITS) begin
            in_reg[5'd23 - cnt_reg[4:0]] <= sdi_s2_reg;
         end
         if (cnt_reg != `CNT_MAX) begin
            cnt_reg <= cnt_reg + 6'd1;
         end
      end
   end

   // Output shifting: first bit at frame start, next on each rising edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out1_reg <= {`OUT_W{1'b0}};
         out2_reg <= 18'h00000;
         first_serial_out <= 1'b0;
         first_serial_oe <= 1'b0;
         second_serial_out <= 1'b0;
         second_serial_oe <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= cs_fall; // RULE_18
         if (cs_fall) begin
            out1_reg <= {t1[62:20], 1'b0};
            out2_reg <= {t2[62:46], 1'b0};
            first_serial_out <= t1[63];
            second_serial_out <= t2[63];
            first_serial_oe <= 1'b1;
            second_serial_oe <= 1'b1;
         end else if (!active) begin
            first_serial_out <= 1'b0;
            second_serial_out <= 1'b0;
            first_serial_oe <= 1'b0;
            second_serial_oe <= 1'b0;
         end else if (sclk_rise) begin
            first_serial_out <= out1_reg[`OUT_W-1];
            second_serial_out <= out2_reg[17];
            out1_reg <= {out1_reg[`OUT_W-2:0], 1'b0};
            out2_reg <= {out2_reg[16:0], 1'b0};
         end
      end
   end

   // Register writes and read requests taken at frame end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_config <= `PRIMARY_RESET;
         secondary_config <= `SECONDARY_RESET;
         alert_low_reg <= `ALERT_LOW_RESET;
         alert_high_reg <= `ALERT_HIGH_RESET;
         read_pending_reg <= 1'b0;
         read_idx_reg <= 3'h0;
      end else begin
         if (cs_fall) begin
            read_pending_reg <= 1'b0;
         end
         if (do_read) begin
            read_pending_reg <= 1'b1;
            read_idx_reg <= target_register_index;
         end
         if (do_write) begin
            case (target_register_index)
               `IDX_PRIMARY: primary_config <= cmd_data; // RULE_05
               `IDX_SECONDARY: secondary_config <= cmd_data & `SECONDARY_WMASK;
               `IDX_ALERT_LOW: alert_low_reg <= cmd_data;
               `IDX_ALERT_HIGH: alert_high_reg <= cmd_data;
               default: read_idx_reg <= read_idx_reg; // RULE_19
            endcase
         end
      end
   end

   // APB slave: one access cycle, registered answer
   wire apb_setup = psel && !penable && !pready;
   wire apb_access = psel && penable && pready;
   wire clr_reject = apb_access && pwrite && (paddr[31:0] == {28'h0, `APB_STATUS}) &&
                     pwdata[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         alert_sw_reg <= 9'h000;
         reject_reg <= 1'b0;
         reject_cnt_reg <= 8'h00;
      end else begin
         pready <= apb_setup;
         pslverr <= 1'b0; // Error stands with pready only
         if (do_reject) begin
            reject_reg <= 1'b1;
            if (reject_cnt_reg != 8'hFF) begin
               reject_cnt_reg <= reject_cnt_reg + 8'h01;
            end
         end else if (clr_reject) begin
            reject_reg <= 1'b0;
         end
         if (apb_access && pwrite && (paddr == {28'h0, `APB_ALERT_FLAGS})) begin
            alert_sw_reg <= pwdata[8:0] & `ALERT_SW_MASK;
         end
         if (apb_setup) begin
            case (paddr)
               {28'h0, `APB_STATUS}:
                  prdata <= {16'h0000, reject_cnt_reg, 5'h00, active,
                             read_pending_reg, reject_reg};
               {28'h0, `APB_CONFIG_VIEW}:
                  prdata <= {4'h0, alert_high_reg[11:8], secondary_config, primary_config};
               {28'h0, `APB_ALERT_FLAGS}:
                  prdata <= {23'h000000, alert_sw_reg};
               default: begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // spi_register_write_crc_guard

// ==== test/host_spi_model.sv ====
/* Host side of the serial port: frames, clocks and data in, collects both outputs.
   Assumes pclk runs free; serial clock idles high and stands still between frames. */
`timescale 1ns/10ps
module host_spi_model (
   input wire pclk,
   input wire first_serial_out,
   input wire second_serial_out,
   output logic cs_n,
   output logic sclk,
   output logic sdi
);
   logic [43:0] rx_a;
   logic [43:0] rx_b;
   // Idle levels at time zero
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
   end
   // One frame of n clocks, 200 ns each, command MSB first
   task automatic frame(input logic [23:0] cmd, input int n);
      rx_a = '0;
      rx_b = '0;
      @(posedge pclk) cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi <= (i < 24) ? cmd[23 - i] : 1'b0;
         repeat (4) @(posedge pclk);
         sclk <= 1'b0;
         repeat (4) @(posedge pclk);
         rx_a = {rx_a[42:0], first_serial_out};
         rx_b = {rx_b[42:0], second_serial_out};
         sclk <= 1'b1;
      end
      repeat (4) @(posedge pclk);
      cs_n <= 1'b1;
      sdi <= ~sdi; // Released line shows no stale level
      repeat (12) @(posedge pclk);
   endtask
endmodule // host_spi_model

// ==== test/crc_guard_checker.sv ====
/* Timing checks on the guard's ports.
   Assumes binding to the guard's top module; all in the pclk domain. */
`timescale 1ns/10ps
module crc_guard_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire cs_n,
   input wire first_serial_oe,
   input wire second_serial_oe,
   input wire conv_start,
   input wire [11:0] primary_config,
   input wire [11:0] secondary_config
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable && !pready |=> pready)
      else $error("no answer after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_has_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   a_start_after_fall: assert property ($fell(cs_n) |-> ##[1:6] conv_start)
      else $error("no conversion start");
   a_start_in_frame: assert property (conv_start |-> !cs_n ##1 !conv_start [*8])
      else $error("stray conversion start");
   a_oe_idle: assert property (cs_n [*8] |-> !first_serial_oe)
      else $error("output driven outside frame");
   a_oe_framed: assert property ($rose(first_serial_oe) |-> !cs_n)
      else $error("output enabled without frame");
   a_oe_pair_same: assert property (second_serial_oe == first_serial_oe)
      else $error("output enables disagree");
   a_cfg_at_end: assert property ($changed(primary_config) || $changed(secondary_config)
      |-> cs_n)
      else $error("config changed inside frame");
   a_sec_top_zero: assert property (secondary_config[11:9] == 3'h0)
      else $error("unused config bits set");
endmodule // crc_guard_checker
bind spi_register_write_crc_guard crc_guard_checker chk (.pclk, .presetn, .psel, .penable,
   .prdata, .pready, .pslverr, .cs_n, .first_serial_oe, .second_serial_oe, .conv_start,
   .primary_config,
   .secondary_config);

// ==== test/test_spi_register_write_crc_guard.sv ====
/* Bench for the serial write guard: APB master, converter data, host model.
   Assumes the guard, its defines header, the host model and the checker. */
`timescale 1ns/10ps
`include "crc_guard_defines.vh"
module test_spi_register_write_crc_guard;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, er;
   logic [31:0] paddr, pwdata, rd;
   logic [17:0] conv_a_data, conv_b_data;
   logic [11:0] v, pe, se;
   wire [31:0] prdata;
   wire pready, pslverr, cs_n, sclk, sdi, conv_start;
   wire first_serial_out, first_serial_oe, second_serial_out, second_serial_oe;
   wire [11:0] primary_config, secondary_config;
   int error_cnt = 0, check_count = 0, seed = 28, cyc = 0;
   int nb[3] = '{24, 40, 44};
   logic [2:0] nop_idx[4] = '{3'h0, 3'h3, 3'h6, 3'h7};
   spi_register_write_crc_guard DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cs_n, .sclk, .sdi, .first_serial_out,
      .first_serial_oe, .second_serial_out, .second_serial_oe, .conv_a_data, .conv_b_data,
      .conv_start, .primary_config, .secondary_config);
   host_spi_model host (.pclk, .first_serial_out, .second_serial_out, .cs_n, .sclk, .sdi);
   // 40 MHz clock
   initial forever #12.5 pclk = ~pclk;
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task check(input logic [43:0] seen, input logic [43:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Serial checksum, top eight message bits inverted
   function automatic logic [7:0] crc8(input logic [35:0] m, input int len);
      logic [7:0] c;
      logic b;
      c = 8'h00;
      for (int i = len - 1; i >= 0; i--) begin
         b = m[i] ^ (i >= len - 8) ^ c[7];
         c = {c[6:0], 1'b0} ^ (b ? `CRC_POLY : 8'h00);
      end
      return c;
   endfunction
   // Expected first output of a conversion frame
   function automatic logic [43:0] conv_exp(input int dw, input logic one);
      logic [35:0] a, b, m;
      a = conv_a_data & ((36'h1 << dw) - 1);
      b = conv_b_data & ((36'h1 << dw) - 1);
      m = (a << dw) | b;
      return one ? {m, crc8(m, 2 * dw)} : {a, crc8(m, 2 * dw)};
   endfunction
   // Register write frame, optional corrupt checksum
   task automatic wr(input logic [2:0] idx, input logic [11:0] d, input int n, input logic bad);
      logic [15:0] cmd;
      cmd = {1'b1, idx, d};
      host.frame({cmd, crc8(cmd, 16) ^ {7'h0, bad}}, n);
   endtask
   // One APB transfer; waits on pready
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite} <= 4'h0;
      paddr <= '0;
      pwdata <= '0;
      conv_a_data <= 18'($random(seed));
      conv_b_data <= 18'($random(seed));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(0, `APB_CONFIG_VIEW, 0);
      check(rd, 32'h0F000000);
      for (int i = 0; i < 4; i++) begin
         v = 12'($random(seed)) & 12'hFCB;
         pe = v;
         se = v & `SECONDARY_WMASK;
         wr(`IDX_PRIMARY, v, 16, 0);
         check(primary_config, pe);
         wr(`IDX_SECONDARY, v, 16, 0);
         check(secondary_config, se);
         wr(nop_idx[i], ~v, 16, 0);
         check({secondary_config, primary_config}, {se, pe});
      end
      host.frame({1'b0, `IDX_PRIMARY, 20'h0}, 16);
      host.frame(24'h0, 16);
      check(host.rx_a, {1'b0, `IDX_PRIMARY, pe});
      for (int m = 0; m < 3; m++) begin
         wr(`IDX_SECONDARY, (m != 0) ? 12'h100 : 12'h000, 16, 0);
         wr(`IDX_PRIMARY, (m == 2) ? 12'h054 : 12'h010, 16, 0);
         host.frame(24'h0, nb[m]);
         check(host.rx_a, conv_exp((m == 2) ? 18 : 16, m != 0));
         if (m == 0) check(host.rx_b[23:8], conv_b_data[15:0]);
         else check(host.rx_b, 44'h0);
      end
      se = 12'h100;
      host.frame({1'b0, `IDX_SECONDARY, 20'h0}, 16);
      host.frame(24'h0, 24);
      check(host.rx_a, {4'h2, se, crc8({4'h2, se}, 16)});
      wr(`IDX_PRIMARY, 12'h020, 16, 0);
      check(primary_config, 12'h054);
      wr(`IDX_PRIMARY, 12'h020, 24, 0);
      check(primary_config, 12'h020);
      wr(`IDX_SECONDARY, 12'h0AA, 16, 0);
      check(secondary_config, se);
      wr(`IDX_SECONDARY, 12'h0AA, 24, 1);
      check(secondary_config, se);
      apb(0, `APB_STATUS, 0);
      check(rd[15:8], 8'h03);
      check(rd[0], 1'b1);
      apb(1, `APB_STATUS, 1);
      apb(0, `APB_STATUS, 0);
      check(rd[0], 1'b0);
      wr(`IDX_SECONDARY, 12'h0AA, 24, 0);
      check(secondary_config, 12'h0AA);
      wr(`IDX_PRIMARY, 12'h000, 16, 0);
      check(primary_config, 12'h020);
      wr(`IDX_PRIMARY, 12'h000, 24, 0);
      check(primary_config, 12'h000);
      wr(`IDX_PRIMARY, 12'h001, 16, 0);
      check(primary_config, 12'h001);
      apb(1, 32'hC, 32'hFFFFFFFF);
      check(er, 1'b1);
      apb(0, 32'hC, 0);
      check({er, rd}, {1'b1, 32'h0});
      apb(1, `APB_ALERT_FLAGS, $random(seed) | 32'h133);
      apb(0, `APB_ALERT_FLAGS, 0);
      check(rd, 32'h133);
      apb(0, `APB_CONFIG_VIEW, 0);
      check(rd, 32'h0F0AA001);
      give_verdict();
   end
endmodule // test_spi_register_write_crc_guard
